/* logic/dcb_cell_ctrl.sv */
`timescale 1ns/1ps
module dcb_cell_ctrl
  import dcb_pkg::*;
#(
  parameter int NCELL = DCB_NUM_CELLS
)(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst_b,
  input  wire logic [2*NCELL-1:0] i_action,
  input  wire logic [NCELL-1:0]   i_enable,
  input  wire logic [NCELL-1:0]   i_peak_hit,
  input  wire logic [NCELL-1:0]   i_zero_hit,
  output logic      [NCELL-1:0]   o_primary_gate,
  output logic      [NCELL-1:0]   o_secondary_gate
);

  typedef enum logic [1:0] {
    DCB_PH_OFF,
    DCB_PH_RAMP_UP,
    DCB_PH_RAMP_DN
  } dcb_phase_t;

  typedef struct packed {
    dcb_phase_t [NCELL-1:0] phase;
    logic       [NCELL-1:0] pri;
    logic       [NCELL-1:0] sec;
  } dcb_cell_st_t;

  dcb_cell_st_t st_ff;
  dcb_cell_st_t nxt_st;
  dcb_act_t     act;

  always_comb
  begin
    nxt_st = st_ff;
    act    = DCB_ACT_NONE;
    for (int k = 0; k < NCELL; k++)
    begin
      // Cell 1 sits in the top pair of the command
      act = dcb_act_t'(i_action[2*(NCELL-1-k) +: 2]);
      if (!i_enable[k] || act == DCB_ACT_NONE)
      begin
        nxt_st.phase[k] = DCB_PH_OFF;
      end
      else
      begin
        case (st_ff.phase[k])
          DCB_PH_OFF:     nxt_st.phase[k] = DCB_PH_RAMP_UP;
          DCB_PH_RAMP_UP: nxt_st.phase[k] = i_peak_hit[k] ? DCB_PH_RAMP_DN : DCB_PH_RAMP_UP;
          DCB_PH_RAMP_DN: nxt_st.phase[k] = i_zero_hit[k] ? DCB_PH_RAMP_UP : DCB_PH_RAMP_DN;
          default:        nxt_st.phase[k] = DCB_PH_OFF;
        endcase
      end
      // Charge: secondary up, primary down; sync discharge: primary up, secondary down; nonsync discharge: primary up only
      nxt_st.pri[k] = 1'b0;
      nxt_st.sec[k] = 1'b0;
      case (act)
        DCB_ACT_CHARGE:                                       // see [R13]
        begin
          nxt_st.sec[k] = (nxt_st.phase[k] == DCB_PH_RAMP_UP);
          nxt_st.pri[k] = (nxt_st.phase[k] == DCB_PH_RAMP_DN);
        end
        DCB_ACT_DIS_SYNC:                                     // see [R14]
        begin
          nxt_st.pri[k] = (nxt_st.phase[k] == DCB_PH_RAMP_UP);
          nxt_st.sec[k] = (nxt_st.phase[k] == DCB_PH_RAMP_DN);
        end
        DCB_ACT_DIS_NONSYNC:                                  // see [R12]
        begin
          nxt_st.pri[k] = (nxt_st.phase[k] == DCB_PH_RAMP_UP);
        end
        default:
        begin
          nxt_st.pri[k] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_primary_gate   = st_ff.pri;
  assign o_secondary_gate = st_ff.sec;

endmodule // dcb_cell_ctrl

/* logic/dcb_chain_port.sv */
// Overview of operation
// [R1] Transactions happen only while chain select is low; low starts, high ends.
// [R2] First eight bits after select falls, MSB first, form the command byte.
// [R3] Command byte passes straight up so all devices see it together.
// [R4] Top five bits must be 10101, else ignore data until select re-toggles.
// [R5] Bits six and seven pick write, read back, read status or execute.
// [R6] Host sets the last bit so the command byte has even parity.
// [R7] Parity error stops execution at once and ignores data, address regardless.
// [R8] Write data not a multiple of 16 bits is discarded; holding register cleared.
// [R9] Rejected write keeps running command; a later execute turns balancing off.
// [R10] Sixteen bits per device, MSB first; first word belongs to topmost device.
// [R11] Balance word: twelve action bits cell 1 to 6, four check bits lowest.
// [R12] Cell action pair: none, nonsync discharge, sync discharge, charge.
// [R13] Charge: secondary ramps to peak, then primary ramps down to zero, repeat.
// [R14] Sync discharge: primary ramps to peak, secondary ramps to zero, repeat.
// [R15] Reset gives command byte 0x00 and balance holding word 0x000F.
// [R16] Single transformer mode ignores commands activating more than one cell.
// [R17] Secondary overvoltage pauses balancing, keeps command, resumes when cleared.
// [R18] Voltage mode select high marks bottom device; low gives current mode.
// [R19] Top-of-stack select high makes this the chain top; others tie low.
// [R20] Select and clock go up unchanged; data direction follows write or read.
// [R21] Open-drain data output serves the bottom device only.
// [R22] Between devices logic levels map to current levels outside this logic.
// [R23] Execute starts the last accepted command now; further data is ignored.
// [R24] CRC x^4+x+1 over all 16 bits must leave zero remainder to accept.
// [R25] Check bits of written and read-back words travel inverted.
// [R26] Read data goes out 16 bits per device, MSB first, bottom device first.
// [R27] Data is sampled on the rising clock edge and changed on the falling.
`timescale 1ns/1ps
module dcb_chain_port
  import dcb_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_chain_clock_in,
  input  wire logic        i_chain_select_in,
  input  wire logic        i_low_side_data,
  output logic             o_low_side_data,
  output logic             o_low_side_data_oe_b,
  output logic             o_open_drain_data_out,
  output logic             o_open_drain_data_out_oe_b,
  output logic             o_chain_select_out,
  output logic             o_chain_clock_out,
  input  wire logic        i_high_side_data,
  output logic             o_high_side_data,
  output logic             o_high_side_data_oe_b,
  input  wire logic        i_top_of_stack_select,
  input  wire logic        i_port_voltage_mode,
  input  wire logic        i_transformer_single,
  output logic             o_low_side_current_mode,
  input  wire logic [5:0]  i_peak_hit,
  input  wire logic [5:0]  i_zero_hit,
  input  wire logic [5:0]  i_gate_drive_ok,
  input  wire logic        i_cells_not_ov,
  input  wire logic        i_sec_not_ov,
  input  wire logic        i_temp_ok,
  output logic [5:0]       o_primary_gate,
  output logic [5:0]       o_secondary_gate,
  output logic             o_balancing,
  output logic [7:0]       o_command_byte,
  output logic [15:0]      o_balance_holding
);

  typedef enum logic [1:0] {
    DCB_FR_CMD,
    DCB_FR_WRITE,
    DCB_FR_READ,
    DCB_FR_IGNORE
  } dcb_frame_t;

  // Per-frame state on the link clock, cleared while select is high
  typedef struct packed {
    dcb_frame_t  phase;
    logic [3:0]  bit_cnt;
    logic [6:0]  cmd_sr;
    logic [3:0]  data_cnt;
  } dcb_frame_st_t;

  // Link state that outlives the frame for the reference domain to read
  typedef struct packed {
    logic [7:0]  cap_cmd;
    logic [15:0] word_sr;
    logic [15:0] rd_sr;
    logic        len_ok;
    logic        cmd_tgl;
    logic [11:0] stat_meta;
    logic [11:0] stat_sync;
  } dcb_link_st_t;

  // Falling-edge launch registers
  typedef struct packed {
    logic        up_bit;
    logic        dn_bit;
  } dcb_launch_st_t;

  typedef struct packed {
    logic [2:0]              cfg_meta;
    logic [2:0]              cfg_sync;
    logic [DCB_ANALOG_W-1:0] ana_meta;
    logic [DCB_ANALOG_W-1:0] ana_sync;
    logic                    cs_meta;
    logic                    cs_sync;
    logic                    cs_prev;
    logic                    tgl_meta;
    logic                    tgl_sync;
    logic                    tgl_prev;
    logic [7:0]              cmd_byte;
    logic [15:0]             holding;
    logic [11:0]             exec_cmd;
    logic                    write_pend;
    logic [11:0]             status;
  } dcb_ref_st_t;

  dcb_frame_st_t  fr_ff;
  dcb_frame_st_t  nxt_fr;
  dcb_link_st_t   lk_ff;
  dcb_link_st_t   nxt_lk;
  dcb_launch_st_t ln_ff;
  dcb_launch_st_t nxt_ln;
  dcb_ref_st_t    rf_ff;
  dcb_ref_st_t    nxt_rf;

  logic        frame_rst_b;
  logic        cfg_top;
  logic        cfg_bottom;
  logic        cfg_single;
  logic        up_in;
  logic [7:0]  byte_in;
  logic        cmd_good;
  logic        reading;
  logic [5:0]  peak_s;
  logic [5:0]  zero_s;
  logic [5:0]  gate_ok_s;
  logic        cells_ok_s;
  logic        sec_ok_s;
  logic        temp_ok_s;
  logic [5:0]  cell_active;
  logic [5:0]  gate_stat;
  logic        any_active;
  logic        run_ok;
  logic [5:0]  cell_enable;
  logic [5:0]  sec_gate_raw;
  logic        cmd_evt;
  logic        cs_rise;
  logic        par_ok;
  logic        addr_ok;
  logic        accept;

  // Frame logic is held cleared while select is high
  assign frame_rst_b = i_rst_b & ~i_chain_select_in;                   // see [R1]

  // Straps are static; their synchronised copies also steer the link side
  assign cfg_top    = rf_ff.cfg_sync[0];                               // see [R19]
  assign cfg_bottom = rf_ff.cfg_sync[1];                               // see [R18]
  assign cfg_single = rf_ff.cfg_sync[2];
  assign up_in      = cfg_top ? 1'b0 : i_high_side_data;
  assign byte_in    = {fr_ff.cmd_sr, i_low_side_data};

  always_comb
  begin
    nxt_fr = fr_ff;
    nxt_lk = lk_ff;
    nxt_lk.stat_meta = rf_ff.status;
    nxt_lk.stat_sync = lk_ff.stat_meta;
    cmd_good = (byte_in[7:3] == DCB_CHAIN_ADDR) && !(^byte_in);
    case (fr_ff.phase)
      DCB_FR_CMD:
      begin
        nxt_fr.cmd_sr = byte_in[6:0];                                  // see [R2]
        if (fr_ff.bit_cnt == DCB_CNT_LAST_CMD)
        begin
          nxt_lk.cap_cmd = byte_in;
          nxt_lk.cmd_tgl = ~lk_ff.cmd_tgl;
          nxt_lk.len_ok  = 1'b0;
          nxt_fr.phase   = DCB_FR_IGNORE;                              // see [R4] [R7]
          if (cmd_good)
          begin
            case (dcb_op_t'(byte_in[2:1]))                             // see [R5]
              DCB_OP_WRITE:
              begin
                nxt_fr.phase = DCB_FR_WRITE;
              end
              DCB_OP_READBACK:
              begin
                nxt_lk.rd_sr = dcb_word(rf_ff.holding[15:4]);          // see [R25]
                nxt_fr.phase = DCB_FR_READ;
              end
              DCB_OP_STATUS:
              begin
                nxt_lk.rd_sr = dcb_word(lk_ff.stat_sync);
                nxt_fr.phase = DCB_FR_READ;
              end
              default:
              begin
                nxt_fr.phase = DCB_FR_IGNORE;                          // see [R23]
              end
            endcase
          end
        end
        else
        begin
          nxt_fr.bit_cnt = fr_ff.bit_cnt + 4'h1;
        end
      end
      DCB_FR_WRITE:
      begin
        nxt_lk.word_sr  = {lk_ff.word_sr[14:0], i_low_side_data};      // see [R10]
        nxt_fr.data_cnt = fr_ff.data_cnt + 4'h1;
        nxt_lk.len_ok   = (fr_ff.data_cnt == DCB_CNT_LAST_DATA);       // see [R8]
      end
      DCB_FR_READ:
      begin
        nxt_lk.rd_sr = {lk_ff.rd_sr[14:0], up_in};                     // see [R26]
      end
      default:
      begin
        nxt_fr.bit_cnt = fr_ff.bit_cnt;
      end
    endcase
    nxt_ln.up_bit = lk_ff.word_sr[15];
    nxt_ln.dn_bit = lk_ff.rd_sr[15];
  end

  always_ff @(posedge i_chain_clock_in or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
    begin
      fr_ff <= '{phase: DCB_FR_CMD, bit_cnt: DCB_CNT_RESET, cmd_sr: 7'h00,
                 data_cnt: DCB_CNT_RESET};
    end
    else
    begin
      fr_ff <= nxt_fr;                                                 // see [R27]
    end
  end

  always_ff @(posedge i_chain_clock_in or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lk_ff <= '0;
    end
    else
    begin
      lk_ff <= nxt_lk;
    end
  end

  always_ff @(negedge i_chain_clock_in or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ln_ff <= '0;
    end
    else
    begin
      ln_ff <= nxt_ln;                                                 // see [R27]
    end
  end

  // Link pins
  assign reading                    = (fr_ff.phase == DCB_FR_READ);
  assign o_chain_select_out         = i_chain_select_in;               // see [R20]
  assign o_chain_clock_out          = i_chain_clock_in;
  assign o_high_side_data           = (fr_ff.phase == DCB_FR_CMD) ?
                                      i_low_side_data : ln_ff.up_bit;  // see [R3]
  assign o_high_side_data_oe_b      = cfg_top | reading;
  assign o_low_side_data            = ln_ff.dn_bit;
  assign o_low_side_data_oe_b       = ~(reading & ~cfg_bottom);        // see [R20]
  assign o_open_drain_data_out      = 1'b0;
  assign o_open_drain_data_out_oe_b = ~(reading & cfg_bottom & ~ln_ff.dn_bit); // see [R21]
  assign o_low_side_current_mode    = ~cfg_bottom;                     // see [R18] [R22]

  // Synchronised comparator flags
  assign peak_s     = rf_ff.ana_sync[5:0];
  assign zero_s     = rf_ff.ana_sync[11:6];
  assign gate_ok_s  = rf_ff.ana_sync[17:12];
  assign cells_ok_s = rf_ff.ana_sync[18];
  assign sec_ok_s   = rf_ff.ana_sync[19];
  assign temp_ok_s  = rf_ff.ana_sync[20];

  always_comb
  begin
    for (int k = 0; k < DCB_NUM_CELLS; k++)
    begin
      cell_active[k] = (rf_ff.exec_cmd[2*(DCB_NUM_CELLS-1-k) +: 2] != 2'h0); // see [R11]
      gate_stat[DCB_NUM_CELLS-1-k] = cell_active[k] & gate_ok_s[k];
    end
  end

  assign any_active  = |cell_active;
  assign run_ok      = cells_ok_s & sec_ok_s & temp_ok_s;              // see [R17]
  assign cell_enable = cell_active & gate_ok_s & {DCB_NUM_CELLS{run_ok}};
  assign cmd_evt     = rf_ff.tgl_sync ^ rf_ff.tgl_prev;
  assign cs_rise     = rf_ff.cs_sync & ~rf_ff.cs_prev;
  assign par_ok      = ~(^lk_ff.cap_cmd);
  assign addr_ok     = (lk_ff.cap_cmd[7:3] == DCB_CHAIN_ADDR);
  assign accept      = lk_ff.len_ok
                     && (dcb_crc4(lk_ff.word_sr[15:4]) == ~lk_ff.word_sr[3:0])   // see [R24]
                     && !(cfg_single && dcb_multi_cell(lk_ff.word_sr[15:4]));    // see [R16]

  always_comb
  begin
    nxt_rf          = rf_ff;
    nxt_rf.cfg_meta = {i_transformer_single, i_port_voltage_mode, i_top_of_stack_select};
    nxt_rf.cfg_sync = rf_ff.cfg_meta;
    nxt_rf.ana_meta = {i_temp_ok, i_sec_not_ov, i_cells_not_ov, i_gate_drive_ok,
                       i_zero_hit, i_peak_hit};
    nxt_rf.ana_sync = rf_ff.ana_meta;
    nxt_rf.cs_meta  = i_chain_select_in;
    nxt_rf.cs_sync  = rf_ff.cs_meta;
    nxt_rf.cs_prev  = rf_ff.cs_sync;
    nxt_rf.tgl_meta = lk_ff.cmd_tgl;
    nxt_rf.tgl_sync = rf_ff.tgl_meta;
    nxt_rf.tgl_prev = rf_ff.tgl_sync;
    nxt_rf.status   = {gate_stat,
                       {3{any_active}} & {cells_ok_s, sec_ok_s, temp_ok_s}, 3'h0};
    if (cmd_evt)
    begin
      nxt_rf.cmd_byte = lk_ff.cap_cmd;
      if (!par_ok)
      begin
        nxt_rf.exec_cmd   = DCB_EXEC_RESET;                            // see [R7]
        nxt_rf.write_pend = 1'b0;
      end
      else if (addr_ok && dcb_op_t'(lk_ff.cap_cmd[2:1]) == DCB_OP_EXECUTE)
      begin
        nxt_rf.exec_cmd = rf_ff.holding[15:4];                         // see [R23] [R9]
      end
      else if (addr_ok && dcb_op_t'(lk_ff.cap_cmd[2:1]) == DCB_OP_WRITE)
      begin
        nxt_rf.write_pend = 1'b1;
      end
    end
    // Write commits when select rises; running command is left alone
    if (cs_rise && rf_ff.write_pend)
    begin
      nxt_rf.write_pend = 1'b0;
      nxt_rf.holding    = accept ? lk_ff.word_sr : DCB_HOLD_RESET;     // see [R8] [R9]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rf_ff          <= '0;
      rf_ff.cs_meta  <= 1'b1;
      rf_ff.cs_sync  <= 1'b1;
      rf_ff.cs_prev  <= 1'b1;
      rf_ff.cmd_byte <= DCB_CMD_RESET;                                 // see [R15]
      rf_ff.holding  <= DCB_HOLD_RESET;
      rf_ff.exec_cmd <= DCB_EXEC_RESET;
    end
    else
    begin
      rf_ff <= nxt_rf;
    end
  end

  dcb_cell_ctrl #(
    .NCELL            (DCB_NUM_CELLS)
  ) u_cells (
    .i_ref_clk        (i_ref_clk),
    .i_rst_b          (i_rst_b),
    .i_action         (rf_ff.exec_cmd),
    .i_enable         (cell_enable),
    .i_peak_hit       (peak_s),
    .i_zero_hit       (zero_s),
    .o_primary_gate   (o_primary_gate),
    .o_secondary_gate (sec_gate_raw)
  );

  // Shared transformer routes the one secondary drive to gate one
  assign o_secondary_gate  = cfg_single ? {5'h00, |sec_gate_raw} : sec_gate_raw; // see [R16]
  assign o_balancing       = any_active & run_ok;
  assign o_command_byte    = rf_ff.cmd_byte;
  assign o_balance_holding = rf_ff.holding;

endmodule // dcb_chain_port

/* logic/dcb_pkg.sv */
package dcb_pkg;

  localparam int          DCB_NUM_CELLS     = 6;
  localparam int          DCB_MSG_W         = 12;
  localparam int          DCB_WORD_W        = 16;
  localparam int          DCB_CRC_W         = 4;
  localparam int          DCB_CMD_BITS      = 8;
  localparam int          DCB_ANALOG_W      = 21;

  localparam logic [4:0]  DCB_CHAIN_ADDR    = 5'h15;
  localparam logic [3:0]  DCB_CRC_POLY      = 4'h3;
  localparam logic [7:0]  DCB_CMD_RESET     = 8'h00;
  localparam logic [15:0] DCB_HOLD_RESET    = 16'h000F;
  localparam logic [11:0] DCB_EXEC_RESET    = 12'h000;
  localparam logic [3:0]  DCB_CNT_LAST_CMD  = 4'h7;
  localparam logic [3:0]  DCB_CNT_LAST_DATA = 4'hF;
  localparam logic [3:0]  DCB_CNT_RESET     = 4'h0;

  typedef enum logic [1:0] {
    DCB_OP_WRITE,
    DCB_OP_READBACK,
    DCB_OP_STATUS,
    DCB_OP_EXECUTE
  } dcb_op_t;

  typedef enum logic [1:0] {
    DCB_ACT_NONE,
    DCB_ACT_DIS_NONSYNC,
    DCB_ACT_DIS_SYNC,
    DCB_ACT_CHARGE
  } dcb_act_t;

  // Remainder of msg * x^4 modulo x^4 + x + 1, message MSB first
  function automatic logic [3:0] dcb_crc4(input logic [11:0] msg);
    logic [3:0] crc;
    logic       fb;
    crc = 4'h0;
    for (int i = 11; i >= 0; i--)
    begin
      fb  = crc[3] ^ msg[i];
      crc = {crc[2:0], 1'b0} ^ (fb ? DCB_CRC_POLY : 4'h0);
    end
    return crc;
  endfunction

  // Message with its check bits appended inverted
  function automatic logic [15:0] dcb_word(input logic [11:0] msg);
    return {msg, ~dcb_crc4(msg)};
  endfunction

  function automatic logic dcb_multi_cell(input logic [11:0] msg);
    int n;
    n = 0;
    for (int k = 0; k < DCB_NUM_CELLS; k++)
    begin
      if (msg[2*k +: 2] != 2'h0)
      begin
        n++;
      end
    end
    return (n > 1);
  endfunction

endpackage

/* tb/dcb_chain_port_assertions.sv */
`timescale 1ns/1ps
module dcb_chain_port_chk (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  input wire logic        i_chain_clock_in,
  input wire logic        i_chain_select_in,
  input wire logic        i_low_side_data,
  input wire logic        i_top_of_stack_select,
  input wire logic        i_port_voltage_mode,
  input wire logic        o_low_side_data_oe_b,
  input wire logic        o_open_drain_data_out,
  input wire logic        o_open_drain_data_out_oe_b,
  input wire logic        o_chain_select_out,
  input wire logic        o_chain_clock_out,
  input wire logic        o_high_side_data,
  input wire logic        o_high_side_data_oe_b,
  input wire logic        o_low_side_current_mode,
  input wire logic        o_balancing,
  input wire logic [7:0]  o_command_byte,
  input wire logic [15:0] o_balance_holding
);
  logic [4:0] lnk_cnt_ff;
  logic [1:0] rst_age_ff;

  always_ff @(posedge i_chain_clock_in or posedge i_chain_select_in)
  begin
    if (i_chain_select_in)
      lnk_cnt_ff <= 5'h00;
    else if (lnk_cnt_ff != 5'h1F)
      lnk_cnt_ff <= lnk_cnt_ff + 5'h01;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rst_age_ff <= 2'h0;
    else if (rst_age_ff != 2'h3)
      rst_age_ff <= rst_age_ff + 2'h1;
  end

  sel_copy_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      o_chain_select_out == i_chain_select_in) else $error("select not forwarded");
  clk_copy_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      o_chain_clock_out == i_chain_clock_in) else $error("clock not forwarded");
  cmd_pass_a:
    assert property (@(posedge i_chain_clock_in) disable iff (!i_rst_b || i_chain_select_in)
      lnk_cnt_ff < 5'h08 |-> o_high_side_data == i_low_side_data)
    else $error("command bit not passed up");
  od_cmd_rel_a:
    assert property (@(posedge i_chain_clock_in) disable iff (!i_rst_b || i_chain_select_in)
      lnk_cnt_ff < 5'h08 |-> o_open_drain_data_out_oe_b) else $error("drive in command");
  od_idle_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      i_chain_select_in && $past(i_chain_select_in) |-> o_open_drain_data_out_oe_b)
    else $error("data driven while deselected");
  od_low_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      o_open_drain_data_out == 1'b0) else $error("open drain drives high");
  top_rel_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      rst_age_ff == 2'h3 && i_top_of_stack_select |-> o_high_side_data_oe_b)
    else $error("top device drives upward");
  port_mode_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      rst_age_ff == 2'h3 |-> o_low_side_current_mode == !i_port_voltage_mode)
    else $error("port mode wrong");
  bottom_quiet_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      rst_age_ff == 2'h3 && i_port_voltage_mode |-> o_low_side_data_oe_b)
    else $error("bottom drives low side");
  reset_val_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      $rose(i_rst_b) |-> o_command_byte == 8'h00 && o_balance_holding == 16'h000F)
    else $error("reset values wrong");
  parity_stop_a:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      $changed(o_command_byte) && ^o_command_byte |-> ##[0:8] !o_balancing)
    else $error("odd parity did not stop");

  cover property (@(posedge i_ref_clk) $rose(o_balancing));
  cover property (@(posedge i_ref_clk) $changed(o_balance_holding));
  cover property (@(posedge i_ref_clk) !o_open_drain_data_out_oe_b);
endmodule // dcb_chain_port_chk

bind dcb_chain_port dcb_chain_port_chk u_chk (
  .i_ref_clk, .i_rst_b, .i_chain_clock_in, .i_chain_select_in, .i_low_side_data,
  .i_top_of_stack_select, .i_port_voltage_mode, .o_low_side_data_oe_b,
  .o_open_drain_data_out, .o_open_drain_data_out_oe_b, .o_chain_select_out,
  .o_chain_clock_out, .o_high_side_data, .o_high_side_data_oe_b,
  .o_low_side_current_mode, .o_balancing, .o_command_byte, .o_balance_holding
);

/* tb/dcb_host_model.sv */
`timescale 1ns/1ps
module dcb_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_od,
  input  wire logic i_od_oe_b,
  output logic      o_clk,
  output logic      o_sel_b,
  output logic      o_sdi,
  output logic      o_hsd
);
  initial
  begin
    o_clk   = 1'b0;
    o_sel_b = 1'b1;
    o_sdi   = 1'b1;
    o_hsd   = 1'b0;
  end

  // One frame: command byte, n data bits MSB first, 16 read bits kept
  task automatic frame(input logic [7:0] cmd, input logic [63:0] dat, input int n,
                       output logic [15:0] rd);
    logic [71:0] bits;
    bits = {cmd, dat};
    rd = 16'h0000;
    @(posedge i_ref_clk);
    #1 o_sel_b = 1'b0;
    #3;
    for (int i = 0; i < 8 + n; i++)
    begin
      o_sdi = bits[71-i];
      o_hsd = ~o_hsd;
      #3 o_clk = 1'b1;
      if (i >= 8 && i < 24)
        rd = {rd[14:0], i_od_oe_b ? 1'b1 : i_od};
      #3 o_clk = 1'b0;
    end
    #3 o_sel_b = 1'b1;
    o_sdi = ~o_sdi;
    repeat (10) @(posedge i_ref_clk);
  endtask
endmodule // dcb_host_model

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        i_ref_clk;
  logic        i_rst_b;
  logic        lk_clk, lk_sel_b, lk_sdi, lk_hsd;
  logic        od, od_oe_b, bal, sec_ok, single;
  logic [5:0]  peak, zero, pri_g, sec_g;
  logic [7:0]  cmd_byte;
  logic [15:0] holding;
  logic [15:0] rd;
  logic [11:0] msg;
  integer      seed;
  int          num_errors;
  int          n_checks;

  always #12.5 i_ref_clk = ~i_ref_clk;

  dcb_chain_port DUT (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_chain_clock_in(lk_clk),
    .i_chain_select_in(lk_sel_b), .i_low_side_data(lk_sdi), .o_low_side_data(),
    .o_low_side_data_oe_b(), .o_open_drain_data_out(od),
    .o_open_drain_data_out_oe_b(od_oe_b), .o_chain_select_out(), .o_chain_clock_out(),
    .i_high_side_data(lk_hsd), .o_high_side_data(), .o_high_side_data_oe_b(),
    .i_top_of_stack_select(1'b1), .i_port_voltage_mode(1'b1),
    .i_transformer_single(single), .o_low_side_current_mode(), .i_peak_hit(peak),
    .i_zero_hit(zero), .i_gate_drive_ok(6'h3F), .i_cells_not_ov(1'b1),
    .i_sec_not_ov(sec_ok), .i_temp_ok(1'b1), .o_primary_gate(pri_g), .o_secondary_gate(sec_g),
    .o_balancing(bal), .o_command_byte(cmd_byte), .o_balance_holding(holding)
  );

  dcb_host_model host (
    .i_ref_clk(i_ref_clk), .i_od(od), .i_od_oe_b(od_oe_b), .o_clk(lk_clk),
    .o_sel_b(lk_sel_b), .o_sdi(lk_sdi), .o_hsd(lk_hsd)
  );

  function automatic logic [3:0] crc_of(input logic [11:0] m);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 11; i >= 0; i--)
      c = {c[2:0], 1'b0} ^ ((c[3] ^ m[i]) ? 4'h3 : 4'h0);
    return c;
  endfunction

  function automatic logic [15:0] word_of(input logic [11:0] m);
    return {m, ~crc_of(m)};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] cmd, input logic [63:0] dat, input int n);
    host.frame(cmd, dat, n, rd);
  endtask

  task automatic write(input logic [15:0] w);
    send(8'hA9, {w, 48'h0}, 16);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge i_ref_clk)
  begin
    peak <= 6'($random(seed));
    zero <= 6'($random(seed));
  end

  initial
  begin
    #100000;
    num_errors++;
    close_out();
  end

  initial
  begin
    seed = 32'h8D10;
    i_ref_clk = 1'b0;
    i_rst_b = 1'b0;
    sec_ok = 1'b1;
    single = 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    check({8'h00, cmd_byte}, 16'h0000);
    check(holding, 16'h000F);
    for (int k = 0; k < 4; k++)
    begin
      msg = (k == 3) ? 12'h400 : 12'($random(seed));
      write(word_of(msg));
      check(holding, word_of(msg));
      check({8'h00, cmd_byte}, 16'h00A9);
      send(8'hAA, 64'h0, 16);
      check(rd, word_of(msg));
      send(8'hAF, 64'h0, 0);
      check({15'h0, bal}, {15'h0, msg != 12'h000});
    end
    send(8'hAC, 64'h0, 16);
    check(16'(rd[15:4]), 16'h0838);
    check(16'(rd[3:0]), {12'h000, ~crc_of(12'h838)});
    check({10'h000, sec_g}, 16'h0000);
    check({10'h000, pri_g & 6'h3E}, 16'h0000);
    @(posedge i_ref_clk) sec_ok <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    check({15'h0, bal}, 16'h0000);
    sec_ok <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    check({15'h0, bal}, 16'h0001);
    send(8'hAE, 64'h0, 0);
    check({15'h0, bal}, 16'h0000);
    check({10'h000, pri_g | sec_g}, 16'h0000);
    send(8'hAF, 64'h0, 0);
    check({15'h0, bal}, 16'h0001);
    send(8'hA9, {word_of(12'h030), 48'h0}, 15);
    check(holding, 16'h000F);
    check({15'h0, bal}, 16'h0001);
    send(8'hAF, 64'h0, 0);
    check({15'h0, bal}, 16'h0000);
    write(word_of(12'h030));
    send(8'h2B, {word_of(12'h0C0), 48'h0}, 16);
    check(holding, word_of(12'h030));
    send(8'hA9, {12'h030, crc_of(12'h030), 48'h0}, 16);
    check(holding, 16'h000F);
    @(posedge i_ref_clk) single <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    write(word_of(12'hA00));
    check(holding, 16'h000F);
    write(word_of(12'h030));
    check(holding, word_of(12'h030));
    single <= 1'b0;
    send(8'hA9, {word_of(12'h0C0), word_of(12'h003), 32'h0}, 32);
    check(holding, word_of(12'h003));
    close_out();
  end
endmodule // testbench
